/* verilog/dmh_consts.svh */
// Constants for the DVM message handler: field positions, codes, attributes.
// Assumes DVM messages arrive with the usual snoop-address encoding.
`ifndef DMH_CONSTS_SVH
`define DMH_CONSTS_SVH

// Message fields in the snoop address
`define DMH_TYPE_HI 14
`define DMH_TYPE_LO 12
`define DMH_SEC_HI 9
`define DMH_SEC_LO 8
`define DMH_MULTI_BIT 0

// Message type codes
`define DMH_TYPE_TLBI 3'h0
`define DMH_TYPE_SYNC 3'h4

// Security codes
`define DMH_SEC_BOTH 2'h0
`define DMH_SEC_S 2'h2
`define DMH_SEC_NS 2'h3

// Snoop response and completion read attributes
`define DMH_CRRESP 5'h00
`define DMH_ARPROT 3'h0
`define DMH_ARDOMAIN 2'h1
`define DMH_ARSNOOP_CPL 4'hE
`define DMH_ARLEN 8'h00

`endif

/* verilog/dmh_pkg.sv */
// Types for the DVM message handler.
// Assumes dmh_consts.svh supplies the numeric constants.
package dmh_pkg;

  typedef enum logic [4:0] {
    S_IDLE = 5'h01,
    S_INVAL = 5'h02,
    S_RESP = 5'h04,
    S_DRAIN = 5'h08,
    S_DONE = 5'h10
  } dmh_state_t;

endpackage : dmh_pkg

/* verilog/dmh_complete_issuer.sv */
// Issues one DVM Complete read and accepts its single data beat.
// Assumes start_in is a one-cycle pulse while the issuer is idle.
`timescale 1ns/100ps
`include "dmh_consts.svh"

module dmh_complete_issuer #(
  parameter int DATA_W = 128,
  parameter int ID_W = 4
) (
  // Clock, reset, enable
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  // Control
  input wire logic start_in,
  output logic done_out,
  // Read address channel
  output logic arvalid_out,
  input wire logic arready_in,
  output logic [ID_W-1:0] arid_out,
  output logic [7:0] arlen_out,
  output logic [2:0] arsize_out,
  output logic [2:0] arprot_out,
  output logic [1:0] ardomain_out,
  output logic [3:0] arsnoop_out,
  // Read data channel
  input wire logic rvalid_in,
  output logic rready_out
);

  localparam logic [2:0] SIZE = 3'($clog2(DATA_W / 8));

  logic wait_r;
  logic next_arvalid;
  logic next_wait_r;
  logic next_done;

  always_comb begin
    next_arvalid = arvalid_out;
    next_wait_r = wait_r;
    next_done = 1'b0;
    if (start_in) begin
      next_arvalid = 1'b1;
    end else if (arvalid_out && arready_in) begin
      next_arvalid = 1'b0;
      next_wait_r = 1'b1;
    end
    if (wait_r && rvalid_in) begin
      next_wait_r = 1'b0;
      next_done = 1'b1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      arvalid_out <= 1'b0;
      wait_r <= 1'b0;
      done_out <= 1'b0;
      rready_out <= 1'b0;
    end else if (ce_in) begin
      arvalid_out <= next_arvalid;
      wait_r <= next_wait_r;
      done_out <= next_done;
      rready_out <= 1'b1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      arid_out <= '1;
      arlen_out <= `DMH_ARLEN;
      arsize_out <= SIZE;
      arprot_out <= `DMH_ARPROT;
      ardomain_out <= `DMH_ARDOMAIN;
      arsnoop_out <= `DMH_ARSNOOP_CPL;
    end
  end

  a_cpl_attrs: assert property (@(posedge clk_in) disable iff (rst_in)
    arvalid_out |-> arprot_out == 3'h0 && ardomain_out == 2'h1 &&
      arlen_out == 8'h00 && arsize_out == SIZE)
    else $error("completion read attributes wrong");

  a_ar_holds: assert property (@(posedge clk_in)
    disable iff (rst_in || !ce_in)
    arvalid_out && !arready_in |=> arvalid_out)
    else $error("completion read dropped before accept");

endmodule : dmh_complete_issuer

/* verilog/dmh_message_handler.sv */
// DVM message handler: answers snoop-channel DVM messages, applies
// masked TLB invalidations and issues DVM Complete after syncs.
// Assumes the TLB side acknowledges each invalidation and reports idle.
`timescale 1ns/100ps
`include "dmh_consts.svh"

module dmh_message_handler import dmh_pkg::*; #(
  parameter int ADDR_W = 48,
  parameter int DATA_W = 128,
  parameter int ID_W = 4
) (
  // Clock, reset, enable
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  // Configuration
  input wire logic broadcast_supported_in,
  input wire logic ns_mask_wr_in,
  input wire logic s_mask_wr_in,
  input wire logic mask_val_in,
  output logic ns_mask_out,
  output logic s_mask_out,
  // Snoop address channel
  input wire logic acvalid_in,
  output logic acready_out,
  input wire logic [ADDR_W-1:0] acaddr_in,
  // Snoop response channel
  output logic crvalid_out,
  input wire logic crready_in,
  output logic [4:0] crresp_out,
  // TLB invalidation port
  output logic inv_valid_out,
  input wire logic inv_ready_in,
  output logic [ADDR_W-1:0] inv_addr_out,
  output logic [1:0] inv_scope_out,
  input wire logic tlb_idle_in,
  output logic pending_out,
  // Completion read
  output logic arvalid_out,
  input wire logic arready_in,
  output logic [ID_W-1:0] arid_out,
  output logic [7:0] arlen_out,
  output logic [2:0] arsize_out,
  output logic [2:0] arprot_out,
  output logic [1:0] ardomain_out,
  output logic [3:0] arsnoop_out,
  input wire logic rvalid_in,
  output logic rready_out
);

  if (ADDR_W < 16 || DATA_W < 8 || DATA_W > 1024 || ID_W < 1) begin : g_chk
    $error("dmh_message_handler: unsupported parameters");
  end

  function automatic logic [2:0] msg_type(input logic [ADDR_W-1:0] a);
    return a[`DMH_TYPE_HI:`DMH_TYPE_LO];
  endfunction : msg_type

  // Scope bit 0 non-secure, bit 1 secure, after masking
  function automatic logic [1:0] inv_scope(input logic [ADDR_W-1:0] a,
                                           input logic ns_m,
                                           input logic s_m);
    logic [1:0] sec;
    sec = a[`DMH_SEC_HI:`DMH_SEC_LO];
    return {(sec == `DMH_SEC_S || sec == `DMH_SEC_BOTH) && !s_m,
            (sec == `DMH_SEC_NS || sec == `DMH_SEC_BOTH) && !ns_m};
  endfunction : inv_scope

  dmh_state_t state;
  dmh_state_t next_state;
  logic second_part;
  logic sync_flag;
  logic start;
  logic cpl_done;
  logic take;
  logic [1:0] scope;
  logic next_second_part;
  logic next_sync_flag;
  logic next_start;
  logic next_acready;
  logic next_crvalid;
  logic next_inv_valid;
  logic [ADDR_W-1:0] next_inv_addr;
  logic [1:0] next_inv_scope;
  logic next_pending;
  logic next_ns_mask;
  logic next_s_mask;

  assign take = acvalid_in && acready_out;
  assign scope = inv_scope(acaddr_in, ns_mask_out, s_mask_out);

  always_comb begin
    next_state = state;
    next_second_part = second_part;
    next_sync_flag = sync_flag;
    next_start = 1'b0;
    next_acready = acready_out;
    next_crvalid = crvalid_out;
    next_inv_valid = inv_valid_out;
    next_inv_addr = inv_addr_out;
    next_inv_scope = inv_scope_out;
    next_pending = pending_out;
    next_ns_mask = ns_mask_wr_in ? mask_val_in : ns_mask_out;
    next_s_mask = s_mask_wr_in ? mask_val_in : s_mask_out;
    unique case (state)
      S_IDLE: begin
        if (take) begin
          next_acready = 1'b0;
          next_second_part = !second_part && acaddr_in[`DMH_MULTI_BIT];
          if (!second_part && msg_type(acaddr_in) == `DMH_TYPE_TLBI &&
              scope != 2'h0) begin
            next_inv_valid = 1'b1;
            next_inv_addr = acaddr_in;
            next_inv_scope = scope;
            next_state = S_INVAL;
          end else begin
            next_crvalid = 1'b1;
            next_sync_flag = !second_part &&
                             msg_type(acaddr_in) == `DMH_TYPE_SYNC;
            next_state = S_RESP;
          end
        end else begin
          next_acready = 1'b1;
        end
      end
      S_INVAL: begin
        if (inv_ready_in) begin
          next_inv_valid = 1'b0;
          next_pending = 1'b1;
          next_crvalid = 1'b1;
          next_sync_flag = 1'b0;
          next_state = S_RESP;
        end
      end
      S_RESP: begin
        if (crready_in) begin
          next_crvalid = 1'b0;
          if (!sync_flag) begin
            next_acready = 1'b1;
            next_state = S_IDLE;
          end else if (pending_out) begin
            next_state = S_DRAIN;
          end else begin
            next_start = 1'b1;
            next_state = S_DONE;
          end
        end
      end
      S_DRAIN: begin
        if (tlb_idle_in) begin
          next_start = 1'b1;
          next_state = S_DONE;
        end
      end
      S_DONE: begin
        if (cpl_done) begin
          next_pending = 1'b0;
          next_acready = 1'b1;
          next_state = S_IDLE;
        end
      end
      default: begin
        next_state = S_IDLE;
        next_acready = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state <= S_IDLE;
      second_part <= 1'b0;
      sync_flag <= 1'b0;
      start <= 1'b0;
      acready_out <= 1'b0;
      crvalid_out <= 1'b0;
      crresp_out <= `DMH_CRRESP;
      inv_valid_out <= 1'b0;
      inv_addr_out <= '0;
      inv_scope_out <= 2'h0;
      pending_out <= 1'b0;
      ns_mask_out <= broadcast_supported_in;
      s_mask_out <= broadcast_supported_in;
    end else if (ce_in) begin
      state <= next_state;
      second_part <= next_second_part;
      sync_flag <= next_sync_flag;
      start <= next_start;
      acready_out <= next_acready;
      crvalid_out <= next_crvalid;
      inv_valid_out <= next_inv_valid;
      inv_addr_out <= next_inv_addr;
      inv_scope_out <= next_inv_scope;
      pending_out <= next_pending;
      ns_mask_out <= next_ns_mask;
      s_mask_out <= next_s_mask;
    end
  end

  dmh_complete_issuer #(
    .DATA_W(DATA_W),
    .ID_W(ID_W)
  ) u_issuer (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .ce_in(ce_in),
    .start_in(start),
    .done_out(cpl_done),
    .arvalid_out(arvalid_out),
    .arready_in(arready_in),
    .arid_out(arid_out),
    .arlen_out(arlen_out),
    .arsize_out(arsize_out),
    .arprot_out(arprot_out),
    .ardomain_out(ardomain_out),
    .arsnoop_out(arsnoop_out),
    .rvalid_in(rvalid_in),
    .rready_out(rready_out)
  );

  // Checks
  logic btm_seen;
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      btm_seen <= broadcast_supported_in;
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in || !ce_in);

  sequence s_tlbi_take;
    take && !second_part && msg_type(acaddr_in) == `DMH_TYPE_TLBI;
  endsequence
  sequence s_sync_answered;
    state == S_RESP && crready_in && sync_flag && !pending_out;
  endsequence

  a_ns_masked: assert property (
    s_tlbi_take ##0 (acaddr_in[9:8] == `DMH_SEC_NS && ns_mask_out)
    |=> crvalid_out && !inv_valid_out)
    else $error("masked non-secure invalidate was applied");
  a_ns_applied: assert property (
    s_tlbi_take ##0 (acaddr_in[9:8] == `DMH_SEC_NS && !ns_mask_out)
    |=> inv_valid_out && inv_scope_out == 2'h1)
    else $error("non-secure invalidate not applied");
  a_s_masked: assert property (
    s_tlbi_take ##0 (acaddr_in[9:8] == `DMH_SEC_S && s_mask_out)
    |=> crvalid_out && !inv_valid_out)
    else $error("masked secure invalidate was applied");
  a_s_applied: assert property (
    s_tlbi_take ##0 (acaddr_in[9:8] == `DMH_SEC_S && !s_mask_out)
    |=> inv_valid_out && inv_scope_out == 2'h2)
    else $error("secure invalidate not applied");
  a_other_answered: assert property (
    take && (second_part || (msg_type(acaddr_in) != `DMH_TYPE_TLBI &&
      msg_type(acaddr_in) != `DMH_TYPE_SYNC)) |=> crvalid_out &&
      !inv_valid_out)
    else $error("other message not answered");
  a_crresp_zero: assert property (
    crvalid_out |-> crresp_out == 5'h00)
    else $error("snoop response not zero");
  a_mask_reset: assert property (
    $fell(rst_in) |-> ns_mask_out == btm_seen && s_mask_out == btm_seen)
    else $error("mask reset value wrong");
  a_sync_immediate: assert property (
    s_sync_answered |-> ##2 arvalid_out)
    else $error("sync completion not immediate");
  a_pending_set: assert property (
    inv_valid_out && inv_ready_in |=> pending_out [*2])
    else $error("pending flag not set");
  a_drain_holds: assert property (
    state == S_DRAIN && !tlb_idle_in |=> state == S_DRAIN && !arvalid_out)
    else $error("completion issued before TLB idle");

endmodule : dmh_message_handler

/* tb/dmh_ic_model.sv */
// Interconnect model: sends DVM messages, takes responses and completions.
// Assumes the handler's registered outputs and a synchronous reset.
`timescale 1ns/100ps

module dmh_ic_model #(
  parameter int ADDR_W = 48
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Snoop channels
  output logic acvalid_out,
  input wire logic acready_in,
  output logic [ADDR_W-1:0] acaddr_out,
  input wire logic crvalid_in,
  output logic crready_out,
  // Completion read
  input wire logic arvalid_in,
  output logic arready_out,
  output logic rvalid_out
);
  int n_to = 0;
  int n_cpl = 0;
  int slow = 0;

  initial begin
    acvalid_out = 1'b0;
    acaddr_out = '0;
    crready_out = 1'b0;
    arready_out = 1'b0;
    rvalid_out = 1'b0;
  end

  // One message, held until taken, then its response
  task automatic send(input logic [ADDR_W-1:0] a);
    int i;
    for (i = 0; i < 300 && acready_in !== 1'b1; i++) @(posedge clk_in);
    #1;
    acvalid_out = 1'b1;
    acaddr_out = a;
    for (i = 0; i < 300; i++) begin
      @(posedge clk_in);
      if (acready_in === 1'b1) break;
    end
    n_to += (i == 300);
    #1;
    acvalid_out = 1'b0;
    acaddr_out = ~a;
    repeat (slow) @(posedge clk_in);
    #1;
    crready_out = 1'b1;
    for (i = 0; i < 300; i++) begin
      @(posedge clk_in);
      if (crvalid_in === 1'b1) break;
    end
    n_to += (i == 300);
    #1;
    crready_out = 1'b0;
  endtask : send

  // Completion read answered after an optional stall
  initial begin
    forever begin
      @(posedge clk_in);
      if (arvalid_in === 1'b1 && rst_in === 1'b0) begin
        repeat (slow) @(posedge clk_in);
        #1;
        arready_out = 1'b1;
        @(posedge clk_in);
        #1;
        arready_out = 1'b0;
        n_cpl++;
        repeat (slow) @(posedge clk_in);
        #1;
        rvalid_out = 1'b1;
        @(posedge clk_in);
        #1;
        rvalid_out = 1'b0;
      end
    end
  end
endmodule : dmh_ic_model

/* tb/tb_top.sv */
// Random and corner DVM message traffic against the message handler.
// Assumes the interconnect model and the handler's hand-over timing.
`timescale 1ns/100ps
`include "dmh_consts.svh"

module tb_top;
  logic clk_in, rst_in, ce_in, bcast, ns_wr, s_wr, mval;
  logic ns_m, s_m, acv, acr, crv, crr, invv, invr, idle, pend;
  logic arv, arr, rv, rr;
  logic [4:0] crresp;
  logic [47:0] acaddr, inv_addr, last_addr;
  logic [1:0] scope, last_scope;
  logic [3:0] arid, arsnoop;
  logic [7:0] arlen;
  logic [2:0] arsize, arprot;
  logic [1:0] ardomain;
  int err_count = 0;
  int n_tests = 0;
  int n_inv = 0;
  int n_cr = 0;

  dmh_message_handler dut (.clk_in(clk_in), .rst_in(rst_in), .ce_in(ce_in),
    .broadcast_supported_in(bcast), .ns_mask_wr_in(ns_wr),
    .s_mask_wr_in(s_wr), .mask_val_in(mval), .ns_mask_out(ns_m),
    .s_mask_out(s_m), .acvalid_in(acv), .acready_out(acr),
    .acaddr_in(acaddr), .crvalid_out(crv), .crready_in(crr),
    .crresp_out(crresp), .inv_valid_out(invv), .inv_ready_in(invr),
    .inv_addr_out(inv_addr), .inv_scope_out(scope), .tlb_idle_in(idle),
    .pending_out(pend), .arvalid_out(arv), .arready_in(arr),
    .arid_out(arid), .arlen_out(arlen), .arsize_out(arsize),
    .arprot_out(arprot), .ardomain_out(ardomain), .arsnoop_out(arsnoop),
    .rvalid_in(rv), .rready_out(rr));

  dmh_ic_model icm (.clk_in(clk_in), .rst_in(rst_in), .acvalid_out(acv),
    .acready_in(acr), .acaddr_out(acaddr), .crvalid_in(crv),
    .crready_out(crr), .arvalid_in(arv), .arready_out(arr),
    .rvalid_out(rv));

  initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end

  task automatic check(input string nm, input logic [7:0] e,
                       input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : check

  task automatic summarize;
    err_count += icm.n_to;
    $display("checks %0d errors %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : summarize

  // TLB side and output watch
  always @(posedge clk_in) begin
    if (invv === 1'b1 && invr === 1'b1) begin
      n_inv++;
      last_scope = scope;
      last_addr = inv_addr;
    end
    n_cr += (crv === 1'b1 && crr === 1'b1);
    if (crv === 1'b1) check("crresp", 8'h00, {3'h0, crresp});
    if (arv === 1'b1) begin
      check("arprot", 8'h00, {5'h00, arprot});
      check("ardomain", 8'h01, {6'h00, ardomain});
      check("arlen", 8'h00, arlen);
      check("arsize", 8'h04, {5'h00, arsize});
      check("arid", 8'h0F, {4'h0, arid});
      check("arsnoop", 8'h0E, {4'h0, arsnoop});
    end
    if (rv === 1'b1) check("rready", 8'h01, {7'h00, rr});
    #1;
    invr = invv & 1'($urandom_range(1));
  end

  initial begin
    int k, i, ty, sec, b_inv, b_cpl, b_cr;
    logic nm, sm, fwd, exp_pend, multi, second;
    logic [1:0] es;
    logic [47:0] a;
    rst_in = 1'b1;
    ce_in = 1'b1;
    bcast = 1'b1;
    ns_wr = 1'b0;
    s_wr = 1'b0;
    mval = 1'b0;
    idle = 1'b1;
    exp_pend = 1'b0;
    second = 1'b0;
    void'($urandom(19));
    repeat (3) @(posedge clk_in);
    #1;
    rst_in = 1'b0;
    check("ns_mask", 8'h01, {7'h00, ns_m});
    check("s_mask", 8'h01, {7'h00, s_m});
    for (k = 0; k < 80; k++) begin
      ty = (k < 8) ? k : ((k == 9 || k == 10) ? 0 : $urandom_range(7));
      sec = (k % 3 == 0) ? 0 : 1 + (k % 3);
      nm = (k < 11) ? 1'b0 : 1'($urandom_range(1));
      sm = (k < 11) ? 1'b0 : 1'($urandom_range(1));
      multi = (k == 9);
      a = 48'({$urandom, $urandom});
      a[14:12] = ty[2:0];
      a[9:8] = sec[1:0];
      a[0] = multi;
      @(posedge clk_in);
      #1;
      // Mid-run reset without broadcast support
      if (k == 40) begin
        rst_in = 1'b1;
        bcast = 1'b0;
        repeat (2) @(posedge clk_in);
        #1;
        rst_in = 1'b0;
        check("ns_mask_rst", 8'h00, {7'h00, ns_m});
        check("s_mask_rst", 8'h00, {7'h00, s_m});
        check("pending_rst", 8'h00, {7'h00, pend});
        bcast = 1'b1;
        exp_pend = 1'b0;
        second = 1'b0;
      end
      ns_wr = 1'b1;
      mval = nm;
      @(posedge clk_in);
      #1;
      ns_wr = 1'b0;
      s_wr = 1'b1;
      mval = sm;
      @(posedge clk_in);
      #1;
      s_wr = 1'b0;
      check("ns_mask", {7'h00, nm}, {7'h00, ns_m});
      check("s_mask", {7'h00, sm}, {7'h00, s_m});
      // Clock enable low freezes the mask
      if (k == 20) begin
        ce_in = 1'b0;
        ns_wr = 1'b1;
        mval = !nm;
        repeat (3) @(posedge clk_in);
        #1;
        ns_wr = 1'b0;
        ce_in = 1'b1;
        check("ce_freeze", {7'h00, nm}, {7'h00, ns_m});
      end
      b_inv = n_inv;
      b_cpl = icm.n_cpl;
      b_cr = n_cr;
      icm.slow = $urandom_range(2);
      idle = !(exp_pend && ty == 4);
      icm.send(a);
      if (idle !== 1'b1) begin
        repeat (6) @(posedge clk_in);
        check("early_cpl", 8'h00, 8'(icm.n_cpl - b_cpl));
        #1;
        idle = 1'b1;
      end
      for (i = 0; i < 300 && acr !== 1'b1; i++) @(posedge clk_in);
      if (i == 300) begin
        err_count++;
        summarize();
      end
      es = {sec != 3 && !sm, sec != 2 && !nm};
      fwd = (ty == 0) && (es != 2'h0) && !second;
      exp_pend = fwd ? 1'b1 : ((ty == 4 && !second) ? 1'b0 : exp_pend);
      check("inv_count", {7'h00, fwd}, 8'(n_inv - b_inv));
      if (fwd) check("inv_scope", {6'h00, es}, {6'h00, last_scope});
      if (fwd) begin
        for (i = 0; i < 6; i++) begin
          check("inv_addr", a[i*8 +: 8], last_addr[i*8 +: 8]);
        end
      end
      check("cr_count", 8'h01, 8'(n_cr - b_cr));
      check("cpl_count", {7'h00, ty == 4 && !second},
            8'(icm.n_cpl - b_cpl));
      check("pending", {7'h00, exp_pend}, {7'h00, pend});
      second = multi;
    end
    summarize();
  end
endmodule : tb_top
